// ### src/amp_fault_params.svh
// Timing constants and fixed figures for the amplifier fault supervisor.
// Assumes a 125 MHz core clock (8 ns period).
`ifndef AMP_FAULT_PARAMS_SVH
`define AMP_FAULT_PARAMS_SVH

`define CLK_PERIOD_PS       8000
// DC offset qualifying interval, in ms, and derived cycle count (longer than)
`define DC_QUAL_MS          420
`define DC_QUAL_CYCLES      ((`DC_QUAL_MS * 64'd1000000000) / `CLK_PERIOD_PS)
// Power-up sequence length, in ms, and derived cycle count
`define POWERUP_MS          10
`define POWERUP_CYCLES      ((`POWERUP_MS * 64'd1000000000) / `CLK_PERIOD_PS)
// Duty threshold in percent
`define DC_DUTY_PCT         60
`define CNT_W               32

`endif

// ### src/amp_fault_pkg.sv
// Types shared by the amplifier fault supervisor.
// Assumes nothing beyond the params header.
package amp_fault_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_POWERUP,
    ST_RUN,
    ST_FAULT
  } amp_state_t;
endpackage

// ### src/pin_sync.sv
// Three-flop input synchroniser with agreement filter.
// Assumes the input is asynchronous to clock_i.
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // Pin in, filtered level out
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First flop is read only by the second; level changes once s2 and s3 agree
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic lvl_q;
  // Nothing bypasses the flops: the raw pin may be mid-transition at any edge
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign level_o = lvl_q;
endmodule // pin_sync

// ### src/amp_fault_protection_ctrl.sv
// Fault supervision for a stereo class-D power stage.
// Assumes analog comparators deliver asynchronous level flags and a duty
// comparator per channel flags >60% differential duty with its polarity.
// What this block does
// - Output short: outputs hi-Z, fault low, latched
// - Over-temperature: outputs hi-Z, fault low, latched
// - DC fault after 420 ms same-polarity >60% duty
// - DC fault: fault low, hi-Z, latched
// - Supply out of range: hi-Z, no fault, self-clears
// - Latched faults clear only on shutdown low pulse
// - Power-up sequence lasts 10 ms, inputs biased
// - Shutdown low mutes outputs, low-current state
`timescale 1ns/10ps
`include "amp_fault_params.svh"
module amp_fault_protection_ctrl
  import amp_fault_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Controller pin
  input  wire logic       shutdown_request_low_i,
  // Analog detector flags (asynchronous)
  input  wire logic       overcurrent_i,
  input  wire logic       overtemp_i,
  input  wire logic       supply_under_i,
  input  wire logic       supply_over_i,
  input  wire logic [1:0] duty_over_i,
  input  wire logic [1:0] duty_pol_i,
  // Fault pin, open drain
  output logic            fault_flag_low_o,
  output logic            fault_flag_low_oe_o,
  // Power stage control
  output logic            outputs_enable_o,
  output logic            input_bias_o,
  output logic            low_power_o,
  output logic [2:0]      latched_faults_o
);
  // Timer limits; both fit the counter width with room to spare
  localparam logic [`CNT_W-1:0] DC_QUAL  = `CNT_W'(`DC_QUAL_CYCLES);
  localparam logic [`CNT_W-1:0] PWR_UP   = `CNT_W'(`POWERUP_CYCLES);

  // Synchronised copies of the pins
  logic       shutdown_request_low;
  logic       oc;
  logic       ot;
  logic       uv;
  logic       ov;
  logic [1:0] dov;
  logic [1:0] dpol;
  logic [6:0] raw;
  logic [6:0] syn;

  assign raw = {shutdown_request_low_i, overcurrent_i, overtemp_i, supply_under_i,
                supply_over_i, duty_over_i};

  // One synchroniser per pin input
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_sync
      pin_sync u_sync (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .pin_i     (raw[g]),
        .level_o   (syn[g])
      );
    end
  endgenerate
  assign shutdown_request_low = syn[6];
  assign oc  = syn[5];
  assign ot  = syn[4];
  assign uv  = syn[3];
  assign ov  = syn[2];
  assign dov = syn[1:0];

  // Polarity goes through the same delay as the level, so both age alike
  for (g = 0; g < 2; g = g + 1) begin : g_pol
    pin_sync u_pol (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .pin_i     (duty_pol_i[g]),
      .level_o   (dpol[g])
    );
  end

  amp_state_t state_q;
  logic [`CNT_W-1:0] pu_cnt_q;
  logic [`CNT_W-1:0] dc_cnt_q [2];
  logic              dc_pol_q [2];
  logic [1:0]        dc_hit;
  logic [2:0]        lat_q;
  logic              sdz_prev_q;
  logic              sd_release;

  // A shutdown cycle is low then high again; the release edge clears latches
  assign sd_release = shutdown_request_low && !sdz_prev_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Resets low, so the first high level counts as a release; harmless,
      // as the latches are empty then
      sdz_prev_q <= 1'b0;
    end else begin
      sdz_prev_q <= shutdown_request_low;
    end
  end

  // Duty timers; a polarity flip restarts the count
  for (g = 0; g < 2; g = g + 1) begin : g_dc
    always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        dc_cnt_q[g] <= '0;
        dc_pol_q[g] <= 1'b0;
      end else if (state_q != ST_RUN || !dov[g] || dpol[g] != dc_pol_q[g]) begin
        dc_cnt_q[g] <= '0;
        dc_pol_q[g] <= dpol[g];
      end else if (dc_cnt_q[g] <= DC_QUAL) begin
        dc_cnt_q[g] <= dc_cnt_q[g] + `CNT_W'(1);
      end
    end
    assign dc_hit[g] = dc_cnt_q[g] > DC_QUAL;
  end

  // Latches: {dc, temp, current}; set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lat_q <= 3'h0;
    end else begin
      lat_q <= (sd_release ? 3'h0 : lat_q)
             | {(|dc_hit),
                ot && shutdown_request_low,
                oc && shutdown_request_low};
    end
  end

  // Sequencer
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q  <= ST_OFF;
      pu_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          pu_cnt_q <= '0;
          if (shutdown_request_low && lat_q == 3'h0) begin
            state_q <= ST_POWERUP;
          end else if (shutdown_request_low && !sd_release && lat_q != 3'h0) begin
            // A fault that outlived the release edge waits for another cycle
            state_q <= ST_FAULT;
          end
        end
        ST_POWERUP: begin
          pu_cnt_q <= pu_cnt_q + `CNT_W'(1);
          if (!shutdown_request_low) begin
            state_q <= ST_OFF;
          end else if (lat_q != 3'h0) begin
            state_q <= ST_FAULT;
          end else if (pu_cnt_q >= PWR_UP - `CNT_W'(1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!shutdown_request_low) begin
            state_q <= ST_OFF;
          end else if (lat_q != 3'h0) begin
            state_q <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          // Only a shutdown cycle leaves here, so a latch never self-clears
          if (!shutdown_request_low) begin
            state_q <= ST_OFF;
          end
        end
      endcase
    end
  end

  logic fault_q;
  // The pin is let go while shutdown is held, so a fault looped back onto the
  // shutdown pin can finish the cycle by itself; the latches still hold
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (lat_q != 3'h0) && shutdown_request_low && !sd_release;
    end
  end

  // Open drain: drive low only when a fault is held; supply faults never pull
  assign fault_flag_low_o    = 1'b0;
  assign fault_flag_low_oe_o = fault_q;

  logic en_q;
  // Supply limits gate the drive directly and latch nothing, so the outputs
  // come back a few cycles after the supply does
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= state_q == ST_RUN && lat_q == 3'h0 && shutdown_request_low && !uv && !ov;
    end
  end
  assign outputs_enable_o = en_q;

  logic bias_q;
  logic low_pwr_q;
  // Registered decode so the power-stage controls never glitch on a state change
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bias_q    <= 1'b0;
      low_pwr_q <= 1'b1;
    end else begin
      bias_q    <= state_q == ST_POWERUP || state_q == ST_RUN;
      low_pwr_q <= state_q == ST_OFF;
    end
  end
  assign input_bias_o     = bias_q;
  assign low_power_o      = low_pwr_q;
  assign latched_faults_o = lat_q;
endmodule // amp_fault_protection_ctrl

// ### verif/amp_fault_sva.sv
// Port checker for the fault supervisor.
// Assumes it is bound onto amp_fault_protection_ctrl.
`timescale 1ns/10ps
module amp_fault_sva (
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic       shutdown_request_low_i,
  input wire logic       supply_under_i,
  input wire logic       supply_over_i,
  input wire logic       fault_flag_low_oe_o,
  input wire logic       outputs_enable_o,
  input wire logic       low_power_o,
  input wire logic [2:0] latched_faults_o
);
  logic [3:0] sd_age_q;
  // Cycles since the shutdown pin was last low; saturates so it never wraps
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) sd_age_q <= 4'hF;
    else if (!shutdown_request_low_i) sd_age_q <= 4'h0;
    else if (sd_age_q != 4'hF) sd_age_q <= sd_age_q + 4'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  oc_flag_a: assert property ($rose(latched_faults_o[0]) |=> fault_flag_low_oe_o)
    else $error("short latch without fault flag");
  ot_flag_a: assert property ($rose(latched_faults_o[1]) |=> fault_flag_low_oe_o)
    else $error("thermal latch without fault flag");
  latch_hiz_a: assert property (|latched_faults_o |=> !outputs_enable_o)
    else $error("outputs driven while latched");
  supply_hiz_a: assert property ((supply_under_i || supply_over_i) [*8] |-> !outputs_enable_o)
    else $error("outputs driven on bad supply");
  flag_cause_a: assert property (fault_flag_low_oe_o |-> $past(|latched_faults_o))
    else $error("fault flag without latch");
  clear_only_a: assert property ($fell(|latched_faults_o) |-> sd_age_q < 4'hC)
    else $error("latch cleared without shutdown");
  sd_mute_a: assert property (!shutdown_request_low_i [*8] |-> low_power_o && !outputs_enable_o)
    else $error("shutdown did not mute");
  sd_flag_a: assert property (!shutdown_request_low_i [*8] |-> !fault_flag_low_oe_o)
    else $error("fault flag held during shutdown");
  flag_release_a: assert property ($fell(|latched_faults_o) |=> !fault_flag_low_oe_o)
    else $error("fault flag kept after clear");
endmodule // amp_fault_sva
bind amp_fault_protection_ctrl amp_fault_sva amp_fault_sva_i (.clock_i, .reset_n_i,
  .shutdown_request_low_i, .supply_under_i, .supply_over_i, .fault_flag_low_oe_o,
  .outputs_enable_o, .low_power_o, .latched_faults_o);

// ### verif/amp_controller_model.sv
// Model of the supervising controller on the shutdown pin.
// Assumes one request pulse per recovery, or the loop strap for self-recovery.
`timescale 1ns/10ps
module amp_controller_model (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // Bench requests
  input  wire logic pulse_i,
  input  wire logic loop_i,
  // Fault pin as the device drives it, high while pulled low
  input  wire logic fault_oe_i,
  // Shutdown pin and mute net toward the device
  output logic      shutdown_request_low_o,
  output logic      mute_low_o
);
  logic [3:0] cnt_q;
  // Low while the count runs: settle span after reset, then per request
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt_q <= 4'hF;
    else if (pulse_i) cnt_q <= 4'hA;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  // With the strap fitted, an asserted fault pulls shutdown low by itself
  assign shutdown_request_low_o = (cnt_q == 4'h0) && !(loop_i && fault_oe_i);
  // Inverted fault drives mute, so mute lifts when the fault pin is let go, no later than a restart
  assign mute_low_o = !fault_oe_i;
endmodule // amp_controller_model

// ### verif/amp_fault_protection_ctrl_tb_top.sv
// Self-checking bench for the fault supervisor.
// Assumes power-up is too long to reach run; tests stay in off, power-up and fault.
`timescale 1ns/10ps
module amp_fault_protection_ctrl_tb_top;
  logic       clock_i = 1'b0, reset_n_i = 1'b0, pulse = 1'b0, loop = 1'b0, sd, mute;
  logic       oc = 1'b0, ot = 1'b0, su = 1'b0, so = 1'b0, fl, oe, en, bias, lp;
  logic [1:0] dov = 2'h0, dpol = 2'h0;
  logic [2:0] lf;
  int         n_errors = 0, checks_done = 0;
  initial forever #4 clock_i = ~clock_i;
  amp_controller_model amp_controller_model_i (.clock_i, .reset_n_i, .pulse_i(pulse),
    .loop_i(loop), .fault_oe_i(oe), .shutdown_request_low_o(sd), .mute_low_o(mute));
  amp_fault_protection_ctrl amp_fault_protection_ctrl_i (.clock_i, .reset_n_i,
    .shutdown_request_low_i(sd), .overcurrent_i(oc), .overtemp_i(ot), .supply_under_i(su),
    .supply_over_i(so), .duty_over_i(dov), .duty_pol_i(dpol), .fault_flag_low_o(fl),
    .fault_flag_low_oe_o(oe), .outputs_enable_o(en), .input_bias_o(bias),
    .low_power_o(lp), .latched_faults_o(lf));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic wait_oe(input logic v);
    int k;
    for (k = 0; k < 40 && oe !== v; k++) cyc(1);
  endtask
  task automatic t_start;
    cyc(8);
    chk({oe, en, lp}, 3'h1, "off state");
    cyc(30);
    chk({en, lp, bias}, 3'h1, "power-up state");
    $display("test start done");
  endtask
  task automatic t_latch(input logic [1:0] src);
    @(posedge clock_i) {ot, oc} <= src;
    wait_oe(1'b1);
    chk(lf, {1'b0, src}, "latch set");
    chk({oe, en, lp}, 3'h4, "flag and hi-z");
    chk({fl, mute, 1'b0}, 3'h0, "pin data low, mute on fault");
    @(posedge clock_i) {ot, oc} <= 2'h0;
    cyc(20);
    chk(lf, {1'b0, src}, "latch held");
    @(posedge clock_i) pulse <= 1'b1;
    @(posedge clock_i) pulse <= 1'b0;
    cyc(8);
    chk(lf, {1'b0, src}, "latch held in shutdown");
    chk({oe, en, lp}, 3'h1, "shutdown mutes, flag let go");
    cyc(12);
    chk(lf, 3'h0, "latch cleared on release");
    chk({oe, en, bias}, 3'h1, "flag released, power-up again");
    $display("test latch done");
  endtask
  task automatic t_loop;
    @(posedge clock_i) begin
      loop <= 1'b1;
      oc   <= 1'b1;
    end
    wait_oe(1'b1);
    chk(lf, 3'h1, "loop latch set");
    @(posedge clock_i) oc <= 1'b0;
    cyc(24);
    chk(lf, 3'h0, "loop self-recovered");
    chk({oe, en, bias}, 3'h1, "loop back in power-up");
    @(posedge clock_i) loop <= 1'b0;
    $display("test loop done");
  endtask
  task automatic t_supply(input logic [1:0] src);
    @(posedge clock_i) {so, su} <= src;
    cyc(12);
    chk({oe, en, lf[0]}, 3'h0, "supply hi-z no flag");
    chk({bias, lp, lf[1]}, 3'h4, "supply leaves sequence alone");
    @(posedge clock_i) {so, su} <= 2'h0;
    cyc(12);
    chk(lf, 3'h0, "supply self-clear");
    $display("test supply done");
  endtask
  task automatic t_dc;
    @(posedge clock_i) {dov, dpol} <= 4'hD;
    cyc(100);
    chk(lf, 3'h0, "dc not yet qualified");
    chk({oe, en, lp}, 3'h0, "dc no flag outside run");
    @(posedge clock_i) dov <= 2'h0;
    $display("test dc done");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #160000;
    n_errors++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_start;
    t_latch(2'h1);
    t_latch(2'h2);
    t_loop;
    t_supply(2'h1);
    t_supply(2'h2);
    t_dc;
    final_report;
  end
endmodule // amp_fault_protection_ctrl_tb_top
